/* hdl/ddr_sram_pkg.sv */
// constants shared by both ends of the burst-of-two common-io sram link
// assumes one system clock on both ends; the host makes the link clock
// Notes on behaviour
// R1: build as 512Kx36 or 1Mx18 words
// R2: every access moves exactly two beats
// R3: one shared data bus, never both driving
// R4: address, controls, mask0, data0 on clock rise
// R5: mask1 and data1 on complementary clock rise
// R6: read and write commands on alternating rises
// R7: write data one cycle after command, buffered
// R8: second write beat on following complementary rise
// R9: byte masks sampled per beat, per lane
// R10: first read beat at third complementary rise
// R11: second read beat at fourth clock rise
// R12: echo clocks aligned with read data
// R13: data valid high only during read beats
// R14: second beat flips lowest address bit
package ddr_sram_pkg;
  // organisation select: 1 gives 512K x 36, 0 gives 1M x 18
  localparam bit WIDE_ORG = 1'b1; // R1
  localparam int ADDR_W = WIDE_ORG ? 19 : 20;
  localparam int DATA_W = WIDE_ORG ? 36 : 18;
  localparam int LANE_W = 9; // R9
  localparam int LANES = DATA_W / LANE_W;
  localparam int DEPTH = 1 << ADDR_W;
  // link clock timing, derived from the system clock rate
  localparam int SYS_PERIOD_NS = 40;
  localparam int K_PERIOD_NS = 320;
  localparam int K_CYC = K_PERIOD_NS / SYS_PERIOD_NS;
  localparam int PH_W = 3;
  localparam logic [PH_W-1:0] PH_LAST = PH_W'(K_CYC - 1);
  localparam logic [PH_W-1:0] PH_HALF = PH_W'(K_CYC / 2);
  localparam logic [PH_W-1:0] PH_BEAT1 = PH_W'(K_CYC / 4);
  localparam logic [PH_W-1:0] PH_SETUP = PH_W'((K_CYC * 3) / 4);
  // link cycles a write waits after a read so the bus turns round
  localparam logic [2:0] RD_TURN_CYC = 3'h4;
  // idle levels of the link controls
  localparam logic LOAD_IDLE_N = 1'b1;
  localparam logic [LANES-1:0] MASK_IDLE_N = {LANES{1'b1}};
endpackage

/* hdl/ddr_sram_link_if.sv */
// link between the memory controller end and the sram end
// assumes both ends run on one system clock; bus level resolved here
interface ddr_sram_link_if;
  logic k_p;
  logic k_n;
  logic load_cmd_n;
  logic read_not_write;
  logic [ddr_sram_pkg::ADDR_W-1:0] addr;
  logic [ddr_sram_pkg::LANES-1:0] byte_write_mask_n;
  logic [ddr_sram_pkg::DATA_W-1:0] dq_host;
  logic dq_host_oe;
  logic [ddr_sram_pkg::DATA_W-1:0] dq_dev;
  logic dq_dev_oe;
  logic [ddr_sram_pkg::DATA_W-1:0] dq;
  logic echo_clk_p;
  logic echo_clk_n;
  logic read_valid_out;

  // shared bus level; the sram end wins if both ever drive
  assign dq = dq_dev_oe ? dq_dev : (dq_host_oe ? dq_host : '0);

  modport dev (
    input k_p, k_n, load_cmd_n, read_not_write, addr, byte_write_mask_n, dq,
    output dq_dev, dq_dev_oe, echo_clk_p, echo_clk_n, read_valid_out
  );
  modport host (
    output k_p, k_n, load_cmd_n, read_not_write, addr, byte_write_mask_n,
    output dq_host, dq_host_oe,
    input dq, echo_clk_p, echo_clk_n, read_valid_out
  );
endinterface

/* hdl/ddr_sram_dev.sv */
// sram end: double data rate, burst of two, common io, late write
// assumes link pins are asynchronous to clk_sys_i and change mid-phase
module ddr_sram_dev (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  ddr_sram_link_if.dev link,
  output logic wr_commit_o,
  output logic rd_launch_o
);
  localparam int AW = ddr_sram_pkg::ADDR_W;
  localparam int DW = ddr_sram_pkg::DATA_W;
  localparam int LN = ddr_sram_pkg::LANES;
  localparam int LW = ddr_sram_pkg::LANE_W;

  // two-stage synchronisers for every link input
  logic k_s1_q, k_s2_q, k_s3_q;
  logic kn_s1_q, kn_s2_q, kn_s3_q;
  logic load_s1_q, load_s2_q;
  logic rnw_s1_q, rnw_s2_q;
  logic [AW-1:0] a_s1_q, a_s2_q;
  logic [LN-1:0] m_s1_q, m_s2_q;
  logic [DW-1:0] d_s1_q, d_s2_q;

  // write path state
  logic wr_cmd_q;
  logic [AW-1:0] wr_cmd_addr_q;
  logic wb1_q;
  logic [AW-1:0] wb_addr_q;
  logic [DW-1:0] wb_d0_q;
  logic [LN-1:0] wb_m0_q;

  // read path state
  logic [2:0] rd_st_q;
  logic [AW-1:0] rd_a0_q, rd_a1_q, rd_a2_q;
  logic rd_b1_q;
  logic rd_tail_q;
  logic [DW-1:0] rd_beat1_q;

  // output registers
  logic [DW-1:0] dq_q;
  logic dq_oe_q;
  logic valid_q;
  logic echo_p_q, echo_n_q;
  logic wr_commit_q, rd_launch_q;

  logic [DW-1:0] mem_q [ddr_sram_pkg::DEPTH];

  // edge and command decode on synchronised copies only
  wire k_rise = k_s2_q & ~k_s3_q;
  wire kn_rise = kn_s2_q & ~kn_s3_q;
  wire cmd_load = k_rise & ~load_s2_q;
  wire cmd_read = cmd_load & rnw_s2_q; // R6
  wire cmd_write = cmd_load & ~rnw_s2_q; // R6
  wire burst_low_addr = wb_addr_q[0];
  wire [AW-1:0] wb_addr1 = {wb_addr_q[AW-1:1], ~burst_low_addr}; // R14
  wire rd_low = rd_a2_q[0];
  wire [AW-1:0] rd_addr1 = {rd_a2_q[AW-1:1], ~rd_low}; // R14
  wire launch0 = kn_rise & rd_st_q[2]; // R10
  wire launch1 = k_rise & rd_b1_q; // R11
  wire release_bus = kn_rise & rd_tail_q;
  wire commit = kn_rise & wb1_q; // R8

  // first synchroniser stage, read only by the second
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      k_s1_q <= 1'b0;
      kn_s1_q <= 1'b1; // matches the pin's level in reset, no false edge
      load_s1_q <= ddr_sram_pkg::LOAD_IDLE_N;
      rnw_s1_q <= 1'b1;
      a_s1_q <= '0;
      m_s1_q <= ddr_sram_pkg::MASK_IDLE_N;
      d_s1_q <= '0;
    end else begin
      k_s1_q <= link.k_p;
      kn_s1_q <= link.k_n;
      load_s1_q <= link.load_cmd_n;
      rnw_s1_q <= link.read_not_write;
      a_s1_q <= link.addr;
      m_s1_q <= link.byte_write_mask_n;
      d_s1_q <= link.dq;
    end
  end

  // second stage, plus a third for the clocks to find edges
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      k_s2_q <= 1'b0;
      k_s3_q <= 1'b0;
      kn_s2_q <= 1'b1;
      kn_s3_q <= 1'b1;
      load_s2_q <= ddr_sram_pkg::LOAD_IDLE_N;
      rnw_s2_q <= 1'b1;
      a_s2_q <= '0;
      m_s2_q <= ddr_sram_pkg::MASK_IDLE_N;
      d_s2_q <= '0;
    end else begin
      k_s2_q <= k_s1_q;
      k_s3_q <= k_s2_q;
      kn_s2_q <= kn_s1_q;
      kn_s3_q <= kn_s2_q;
      load_s2_q <= load_s1_q;
      rnw_s2_q <= rnw_s1_q;
      a_s2_q <= a_s1_q;
      m_s2_q <= m_s1_q;
      d_s2_q <= d_s1_q;
    end
  end

  // late write: hold the command until its data arrives a cycle later
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_cmd_q <= 1'b0;
      wr_cmd_addr_q <= '0;
    end else if (k_rise) begin
      wr_cmd_q <= cmd_write; // R4 R7
      wr_cmd_addr_q <= a_s2_q;
    end
  end

  // first write beat with its own mask on the rise after the command
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wb1_q <= 1'b0;
      wb_addr_q <= '0;
      wb_d0_q <= '0;
      wb_m0_q <= ddr_sram_pkg::MASK_IDLE_N;
    end else if (k_rise && wr_cmd_q) begin
      wb1_q <= 1'b1; // R7
      wb_addr_q <= wr_cmd_addr_q;
      wb_d0_q <= d_s2_q; // R4
      wb_m0_q <= m_s2_q; // R9
    end else if (commit) begin
      wb1_q <= 1'b0;
    end
  end

  // both beats land together once the second one is caught
  // no reset: array contents are undefined at power up
  always_ff @(posedge clk_sys_i) begin
    if (commit) begin
      for (int l = 0; l < LN; l++) begin
        if (!wb_m0_q[l]) begin
          mem_q[wb_addr_q][l*LW +: LW] <= wb_d0_q[l*LW +: LW]; // R9
        end
        if (!m_s2_q[l]) begin
          mem_q[wb_addr1][l*LW +: LW] <= d_s2_q[l*LW +: LW]; // R5 R9
        end
      end
    end
  end

  // read pipeline counts clock rises since the read was taken
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_st_q <= 3'h0;
      rd_a0_q <= '0;
      rd_a1_q <= '0;
      rd_a2_q <= '0;
    end else if (k_rise) begin
      rd_st_q <= {rd_st_q[1:0], cmd_read}; // R4
      rd_a0_q <= a_s2_q;
      rd_a1_q <= rd_a0_q;
      rd_a2_q <= rd_a1_q;
    end
  end

  // beat sequencing: beat0, then beat1, then hand the bus back
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_b1_q <= 1'b0;
      rd_tail_q <= 1'b0;
      rd_beat1_q <= '0;
    end else if (launch0) begin
      rd_b1_q <= 1'b1; // R2
      rd_tail_q <= 1'b0;
      rd_beat1_q <= mem_q[rd_addr1];
    end else if (launch1) begin
      rd_b1_q <= 1'b0;
      rd_tail_q <= 1'b1;
    end else if (release_bus) begin
      rd_tail_q <= 1'b0;
    end
  end

  // bus drive and valid flag; a fresh launch outranks a release
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dq_q <= '0;
      dq_oe_q <= 1'b0;
      valid_q <= 1'b0;
    end else if (launch0) begin
      dq_q <= mem_q[rd_a2_q]; // R10
      dq_oe_q <= 1'b1; // R3
      valid_q <= 1'b1; // R13
    end else if (launch1) begin
      dq_q <= rd_beat1_q; // R11
    end else if (release_bus) begin
      dq_oe_q <= 1'b0; // R3
      valid_q <= 1'b0; // R13
    end
  end

  // echo clocks follow the sampled input clocks on the launch edge,
  // so data and echo edges leave on the same system clock
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      echo_p_q <= 1'b0;
      echo_n_q <= 1'b0;
      wr_commit_q <= 1'b0;
      rd_launch_q <= 1'b0;
    end else begin
      echo_p_q <= k_s2_q; // R12
      echo_n_q <= kn_s2_q; // R12
      wr_commit_q <= commit;
      rd_launch_q <= launch0;
    end
  end

  assign link.dq_dev = dq_q;
  assign link.dq_dev_oe = dq_oe_q;
  assign link.read_valid_out = valid_q;
  assign link.echo_clk_p = echo_p_q;
  assign link.echo_clk_n = echo_n_q;
  assign wr_commit_o = wr_commit_q;
  assign rd_launch_o = rd_launch_q;
endmodule

/* hdl/ddr_sram_host.sv */
// controller end: makes the link clock, schedules commands, moves data
// assumes a user that holds cmd_valid_i until cmd_ready_o takes it
module ddr_sram_host (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  ddr_sram_link_if.host link,
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic [ddr_sram_pkg::ADDR_W-1:0] cmd_addr_i,
  input wire logic [ddr_sram_pkg::DATA_W-1:0] cmd_wdata0_i,
  input wire logic [ddr_sram_pkg::DATA_W-1:0] cmd_wdata1_i,
  input wire logic [ddr_sram_pkg::LANES-1:0] cmd_wbe0_i,
  input wire logic [ddr_sram_pkg::LANES-1:0] cmd_wbe1_i,
  output logic cmd_ready_o,
  output logic [ddr_sram_pkg::DATA_W-1:0] rd_data0_o,
  output logic [ddr_sram_pkg::DATA_W-1:0] rd_data1_o,
  output logic rd_valid_o
);
  localparam int AW = ddr_sram_pkg::ADDR_W;
  localparam int DW = ddr_sram_pkg::DATA_W;
  localparam int LN = ddr_sram_pkg::LANES;

  logic [ddr_sram_pkg::PH_W-1:0] ph_q;
  logic k_q, kn_q;
  logic hold_q, hold_wr_q, ready_q;
  logic [AW-1:0] hold_a_q;
  logic [DW-1:0] hold_d0_q, hold_d1_q;
  logic [LN-1:0] hold_be0_q, hold_be1_q;
  logic slot_q, wr_issued_q, b1_q;
  logic [2:0] blk_q;
  logic [DW-1:0] wb_d0_q, wb_d1_q;
  logic [LN-1:0] wb_be0_q, wb_be1_q;
  logic load_n_q, rnw_q;
  logic [AW-1:0] a_q;
  logic [LN-1:0] m_n_q;
  logic [DW-1:0] dq_q;
  logic dq_oe_q;
  logic ep_s1_q, ep_s2_q, ep_s3_q, en_s1_q, en_s2_q, en_s3_q, v_s1_q, v_s2_q;
  logic [DW-1:0] d_s1_q, d_s2_q, rd0_q, rd1_q;
  logic rv_q;

  // link clock divider; controls change a quarter period from any edge
  wire [ddr_sram_pkg::PH_W-1:0] ph_nxt =
    (ph_q == ddr_sram_pkg::PH_LAST) ? '0 : ph_q + 1'b1;
  wire at_setup = ph_nxt == ddr_sram_pkg::PH_SETUP;
  wire at_beat1 = ph_nxt == ddr_sram_pkg::PH_BEAT1;
  // reads on even slots, writes on odd, writes held off after a read
  wire can_rd = at_setup & hold_q & ~hold_wr_q & ~slot_q; // R6
  wire can_wr = at_setup & hold_q & hold_wr_q & slot_q & (blk_q == 3'h0); // R3 R6
  wire issue = can_rd | can_wr;
  wire take = cmd_valid_i & ready_q;
  wire hold_d = take | (hold_q & ~issue);
  wire ep_rise = ep_s2_q & ~ep_s3_q;
  wire en_rise = en_s2_q & ~en_s3_q;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ph_q <= '0;
      k_q <= 1'b0;
      kn_q <= 1'b1;
    end else begin
      ph_q <= ph_nxt;
      k_q <= ph_nxt < ddr_sram_pkg::PH_HALF;
      // own flop for the complement, so no gate sits on the pin
      kn_q <= ph_nxt >= ddr_sram_pkg::PH_HALF;
    end
  end

  // one-entry command holding register gives back-pressure
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_q <= 1'b0;
      ready_q <= 1'b0;
      hold_wr_q <= 1'b0;
      hold_a_q <= '0;
      {hold_d0_q, hold_d1_q, hold_be0_q, hold_be1_q} <= '0;
    end else begin
      hold_q <= hold_d;
      ready_q <= ~hold_d;
      if (take) begin
        hold_wr_q <= cmd_write_i;
        hold_a_q <= cmd_addr_i;
        {hold_d0_q, hold_d1_q} <= {cmd_wdata0_i, cmd_wdata1_i};
        {hold_be0_q, hold_be1_q} <= {cmd_wbe0_i, cmd_wbe1_i};
      end
    end
  end

  // command slot: load, direction and address for the next clock rise
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slot_q <= 1'b0;
      blk_q <= 3'h0;
      wr_issued_q <= 1'b0;
      load_n_q <= ddr_sram_pkg::LOAD_IDLE_N;
      rnw_q <= 1'b1;
      a_q <= '0;
      {wb_d0_q, wb_d1_q, wb_be0_q, wb_be1_q} <= '0;
    end else if (at_setup) begin
      slot_q <= ~slot_q;
      blk_q <= can_rd ? ddr_sram_pkg::RD_TURN_CYC : (blk_q - (blk_q != 3'h0));
      wr_issued_q <= can_wr; // R7
      load_n_q <= ~issue;
      rnw_q <= ~can_wr;
      a_q <= hold_a_q;
      if (can_wr) begin
        {wb_d0_q, wb_d1_q, wb_be0_q, wb_be1_q} <=
          {hold_d0_q, hold_d1_q, hold_be0_q, hold_be1_q};
      end
    end
  end

  // write data: beat0 a cycle after its command, beat1 half a cycle on
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      b1_q <= 1'b0;
      dq_q <= '0;
      dq_oe_q <= 1'b0;
      m_n_q <= ddr_sram_pkg::MASK_IDLE_N;
    end else if (at_setup) begin
      b1_q <= wr_issued_q; // R2
      dq_q <= wb_d0_q; // R7
      dq_oe_q <= wr_issued_q; // R3
      m_n_q <= wr_issued_q ? ~wb_be0_q : ddr_sram_pkg::MASK_IDLE_N; // R9
    end else if (at_beat1 && b1_q) begin
      b1_q <= 1'b0;
      dq_q <= wb_d1_q; // R8
      m_n_q <= ~wb_be1_q; // R9
    end
  end

  // read return: synchronise, then catch each beat on its echo edge
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {ep_s1_q, ep_s2_q, ep_s3_q, en_s1_q, en_s2_q, en_s3_q} <= 6'h00;
      {v_s1_q, v_s2_q} <= 2'h0;
      {d_s1_q, d_s2_q} <= '0;
    end else begin
      {ep_s1_q, ep_s2_q, ep_s3_q} <= {link.echo_clk_p, ep_s1_q, ep_s2_q};
      {en_s1_q, en_s2_q, en_s3_q} <= {link.echo_clk_n, en_s1_q, en_s2_q};
      {v_s1_q, v_s2_q} <= {link.read_valid_out, v_s1_q};
      {d_s1_q, d_s2_q} <= {link.dq, d_s1_q};
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd0_q <= '0;
      rd1_q <= '0;
      rv_q <= 1'b0;
    end else begin
      rv_q <= ep_rise & v_s2_q;
      if (en_rise && v_s2_q) begin
        rd0_q <= d_s2_q; // R12
      end
      if (ep_rise && v_s2_q) begin
        rd1_q <= d_s2_q; // R12 R14
      end
    end
  end

  assign link.k_p = k_q;
  assign link.k_n = kn_q;
  assign link.load_cmd_n = load_n_q;
  assign link.read_not_write = rnw_q;
  assign link.addr = a_q;
  assign link.byte_write_mask_n = m_n_q;
  assign link.dq_host = dq_q;
  assign link.dq_host_oe = dq_oe_q;
  assign cmd_ready_o = ready_q;
  assign rd_data0_o = rd0_q;
  assign rd_data1_o = rd1_q;
  assign rd_valid_o = rv_q;
endmodule

/* sim/ddr_sram_link_sva.sv */
// link checker: timing of commands, beats and bus ownership
// assumes plain copies of the link interface signals and the system clock
module ddr_sram_link_sva (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic k_p,
  input wire logic k_n,
  input wire logic load_cmd_n,
  input wire logic read_not_write,
  input wire logic [ddr_sram_pkg::LANES-1:0] byte_write_mask_n,
  input wire logic dq_host_oe,
  input wire logic [ddr_sram_pkg::DATA_W-1:0] dq_dev,
  input wire logic dq_dev_oe,
  input wire logic echo_clk_p,
  input wire logic echo_clk_n,
  input wire logic read_valid_out
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  // commands as seen at the link clock rise; one link cycle is 8 clocks
  sequence rd_cmd_s;
    $rose(k_p) && !load_cmd_n && read_not_write;
  endsequence
  sequence wr_cmd_s;
    $rose(k_p) && !load_cmd_n && !read_not_write;
  endsequence
  sequence beat0_s;
    $rose(read_valid_out);
  endsequence
  bus_excl_a: assert property (!(dq_host_oe && dq_dev_oe))
    else $error("both ends drive the data bus");
  k_pair_a: assert property (k_n == !k_p)
    else $error("link clock pair not complementary");
  rd_lat_a: assert property (rd_cmd_s |-> ##[18:28] $rose(read_valid_out))
    else $error("read beat late or missing");
  beat_two_a: assert property (beat0_s |-> ##1 $stable(dq_dev)[*3] ##1 $rose(echo_clk_p))
    else $error("second read beat misplaced");
  echo_align_a: assert property (beat0_s |-> $rose(echo_clk_n))
    else $error("echo clock not with first beat");
  valid_len_a: assert property (beat0_s |-> read_valid_out[*8] ##1 !read_valid_out)
    else $error("read valid length wrong");
  valid_oe_a: assert property (read_valid_out |-> dq_dev_oe)
    else $error("valid without read drive");
  rd_alt_a: assert property (rd_cmd_s |-> ##8 !(!load_cmd_n && read_not_write))
    else $error("reads on adjacent rises");
  wr_alt_a: assert property (wr_cmd_s |-> ##8 !(!load_cmd_n && !read_not_write))
    else $error("writes on adjacent rises");
  wr_late_a: assert property (wr_cmd_s |-> ##8 dq_host_oe ##4 (dq_host_oe && $rose(k_n)))
    else $error("write data not one cycle late");
  wr_len_a: assert property ($rose(dq_host_oe) |-> dq_host_oe[*8] ##1 !dq_host_oe)
    else $error("write burst length wrong");
  mask_idle_a: assert property (!dq_host_oe |-> &byte_write_mask_n)
    else $error("mask active outside write beats");
endmodule

/* sim/ddr_burst2_common_io_sram_port_tb.sv */
// bench: controller end joined to sram end, random traffic checked
// assumes nothing outside; it makes clock, reset and user commands
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
  $display("ERROR %0t: got %h want %h", $time, (a), (e)); end end
module ddr_burst2_common_io_sram_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int A = ddr_sram_pkg::ADDR_W;
  localparam int D = ddr_sram_pkg::DATA_W;
  localparam int L = ddr_sram_pkg::LANES;
  localparam int W = ddr_sram_pkg::LANE_W;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0, cmd_write = 1'b0;
  logic [A-1:0] cmd_addr = '0;
  logic [D-1:0] wdata0 = '0, wdata1 = '0;
  logic [L-1:0] wbe0 = '0, wbe1 = '0;
  logic cmd_ready, rd_valid, wr_commit, rd_launch;
  logic [D-1:0] rd_data0, rd_data1;
  logic [31:0] seed = 32'h0000_0012;
  logic [D-1:0] mem [logic [A-1:0]];
  logic [A-1:0] adrs [6];
  int num_errors = 0;
  int cmp_count = 0;

  ddr_sram_link_if lnk ();
  ddr_sram_host ddr_sram_host_inst (.clk_sys_i(clk_sys), .rst_n_i(rst_n),
    .link(lnk.host), .cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write),
    .cmd_addr_i(cmd_addr), .cmd_wdata0_i(wdata0), .cmd_wdata1_i(wdata1),
    .cmd_wbe0_i(wbe0), .cmd_wbe1_i(wbe1), .cmd_ready_o(cmd_ready),
    .rd_data0_o(rd_data0), .rd_data1_o(rd_data1), .rd_valid_o(rd_valid));
  ddr_sram_dev ddr_sram_dev_inst (.clk_sys_i(clk_sys), .rst_n_i(rst_n),
    .link(lnk.dev), .wr_commit_o(wr_commit), .rd_launch_o(rd_launch));
  ddr_sram_link_sva ddr_sram_link_sva_inst (.clk_sys_i(clk_sys), .rst_n_i(rst_n),
    .k_p(lnk.k_p), .k_n(lnk.k_n), .load_cmd_n(lnk.load_cmd_n),
    .read_not_write(lnk.read_not_write), .byte_write_mask_n(lnk.byte_write_mask_n),
    .dq_host_oe(lnk.dq_host_oe), .dq_dev(lnk.dq_dev), .dq_dev_oe(lnk.dq_dev_oe),
    .echo_clk_p(lnk.echo_clk_p), .echo_clk_n(lnk.echo_clk_n),
    .read_valid_out(lnk.read_valid_out));

  // 25 MHz system clock
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  // xorshift source, fixed start so runs repeat
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // expected word after a masked write of one beat
  function automatic logic [D-1:0] merge(input logic [D-1:0] old,
    input logic [D-1:0] nw, input logic [L-1:0] be);
    logic [D-1:0] r;
    r = old;
    for (int l = 0; l < L; l++) if (be[l]) r[l*W +: W] = nw[l*W +: W];
    return r;
  endfunction

  task automatic print_verdict();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // one user command, held until taken, then waited to completion
  task automatic op(input logic w, input logic [A-1:0] a, input logic [D-1:0] d0,
    input logic [D-1:0] d1, input logic [L-1:0] b0, input logic [L-1:0] b1);
    int n;
    logic [A-1:0] a1;
    logic seen;
    a1 = {a[A-1:1], ~a[0]};
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_addr <= a;
    wdata0 <= d0;
    wdata1 <= d1;
    wbe0 <= b0;
    wbe1 <= b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (cmd_ready !== 1'b1 && n < 300);
    cmd_valid <= 1'b0;
    n = 0;
    seen = 1'b0;
    // done pulses stand one cycle, so every edge is looked at
    do begin
      @(posedge clk_sys);
      n++;
      if (rd_launch === 1'b1) begin
        seen = 1'b1;
      end
    end while ((w ? wr_commit : rd_valid) !== 1'b1 && n < 300);
    `CHK(n < 300, 1'b1);
    `CHK(seen, !w);
    if (w) begin
      mem[a] = merge(mem[a], d0, b0);
      mem[a1] = merge(mem[a1], d1, b1);
    end else begin
      `CHK(rd_data0, mem[a]);
      `CHK(rd_data1, mem[a1]);
    end
  endtask

  // main sequence
  initial begin
    logic [31:0] r;
    repeat (12) @(posedge clk_sys);
    `CHK(cmd_ready, 1'b0);
    `CHK(lnk.load_cmd_n, 1'b1);
    `CHK(lnk.dq_host_oe, 1'b0);
    rst_n <= 1'b1;
    // full writes first: the array wakes up unknown
    foreach (adrs[i]) begin
      adrs[i] = A'(xs());
      op(1'b1, adrs[i], D'({xs(), xs()}), D'({xs(), xs()}), '1, '1);
    end
    // read each word, then its partner, so beat order swaps
    foreach (adrs[i]) begin
      op(1'b0, adrs[i], '0, '0, '0, '0);
      op(1'b0, adrs[i] ^ A'(1), '0, '0, '0, '0);
    end
    // per-beat lane masks; first pass writes no lane at all
    for (int i = 0; i < 10; i++) begin
      r = xs();
      if (i == 0) r = '0;
      if (i == 1) r = 32'h0000_000f;
      op(1'b1, adrs[i%6], D'({xs(), xs()}), D'({xs(), xs()}), r[L-1:0], r[2*L-1:L]);
      op(1'b0, adrs[i%6], '0, '0, '0, '0);
    end
    print_verdict();
  end

  // hang guard, well past the fifteen hundred or so cycles the run needs
  initial begin
    #(1_000_000);
    num_errors++;
    $display("ERROR %0t: run timed out", $time);
    print_verdict();
  end
endmodule
